// [design/lpmc_regs.vh]
// Constants of the low-power mode controller: register map, fields,
// reset values and timing counts.
// Assumes a 32-bit AHB-Lite slave decoding word-aligned addresses.
`ifndef LPMC_REGS_VH
`define LPMC_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define LPMC_CTRL_OFS 8'h00
`define LPMC_STAT_OFS 8'h04
`define LPMC_TSC_OFS 8'h08
`define LPMC_IRQC_OFS 8'h0c

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define LPMC_CTRL_HALT_SEL 0
`define LPMC_CTRL_LONG_DLY 1
`define LPMC_CTRL_PORT_IRQ 2
`define LPMC_CTRL_WDOG_EN 3
`define LPMC_CTRL_RST 4'h0

// ---------------------------------------------------------------
// Timer status/control fields
// ---------------------------------------------------------------
`define LPMC_TSC_OVF_FLAG 7
`define LPMC_TSC_RTI_FLAG 6
`define LPMC_TSC_OVF_EN 5
`define LPMC_TSC_RTI_EN 4
`define LPMC_TSC_RST 8'h00

// ---------------------------------------------------------------
// Interrupt control fields
// ---------------------------------------------------------------
`define LPMC_IRQC_EXT_EN 0
`define LPMC_IRQC_IMASK 1
`define LPMC_IRQC_RST 2'h3

// ---------------------------------------------------------------
// Timing: stabilization delays in processor cycles
// ---------------------------------------------------------------
`define LPMC_SHORT_DLY 12'h010
`define LPMC_LONG_DLY 12'hfe0
`define LPMC_CNT_W 12

`endif

// [design/lpmc_delay.v]
// Wake-up stabilization delay counter.
// Assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module lpmc_delay #(
   parameter W = 12
)(
   input wire clk,
   input wire rst_n,
   input wire start,
   input wire [W-1:0] count,
   output reg busy_r,
   output reg done_r
);
   reg [W-1:0] cnt_r;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_r <= {W{1'b0}};
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         if (start)
         begin
            cnt_r <= count - {{(W-1){1'b0}}, 1'b1};
            busy_r <= 1'b1;
         end
         else if (busy_r)
         begin
            if (cnt_r == {W{1'b0}})
            begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
            else
               cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// [design/lpmc_top.v]
// Low-power mode controller: stop, halt and wait handling, clock gating
// enables, wake-up stabilization delay and AHB-Lite register access.
// Assumes the core pulses STOP_EXEC or WAIT_EXEC for one cycle; wake
// pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`include "lpmc_regs.vh"
module lpmc_top (
   input wire CLK,
   input wire RST_N,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   input wire STOP_EXEC,
   input wire WAIT_EXEC,
   input wire IRQ_N_PIN,
   input wire [3:0] PORT_IRQ_PIN,
   input wire TIMER_OVF_EVT,
   input wire TIMER_RTI_EVT,
   output reg CPU_CLK_EN,
   output reg TIMER_CLK_EN,
   output reg OSC_EN,
   output reg WDOG_RUN,
   output reg WAKE_IRQ,
   output reg LP_ACTIVE
);
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam [4:0] S_RUN = 5'h01;
   localparam [4:0] S_STOP = 5'h02;
   localparam [4:0] S_HALT = 5'h04;
   localparam [4:0] S_WAIT = 5'h08;
   localparam [4:0] S_DLY = 5'h10;
   localparam CW = `LPMC_CNT_W;
   localparam [CW-1:0] SHORT_CNT = `LPMC_SHORT_DLY;
   localparam [CW-1:0] LONG_CNT = `LPMC_LONG_DLY;
   localparam [1:0] IRQC_RST = `LPMC_IRQC_RST;

   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [3:0] ctrl_r;
   reg [7:0] timer_status_control_r;
   reg external_irq_enable_r;
   reg imask_r;
   reg irq_s1_r;
   reg irq_s2_r;
   reg [3:0] port_s1_r;
   reg [3:0] port_s2_r;
   reg [7:0] a_addr_r;
   reg a_wr_r;
   reg stop_osc_r;
   wire dly_busy;
   wire dly_done;
   wire ahb_go;
   wire ext_req;
   wire tmr_req;
   wire enter_stop;
   wire enter_halt;
   wire enter_wait;
   wire dly_start;
   wire [CW-1:0] dly_cnt;
   wire osc_hold;

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   // Data-phase write strobe aimed at one register offset
   function wr_hit;
      input wr;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         wr_hit = wr & (addr == ofs);
      end
   endfunction

   // A timer source requests only while its enable is set
   function tmr_pend;
      input flag;
      input enable;
      begin
         tmr_pend = flag & enable;
      end
   endfunction

   // ---------------------------------------------------------------
   // Wake-source synchronisers
   // ---------------------------------------------------------------
   always @(posedge CLK)
   begin
      if (!RST_N)
      begin
         irq_s1_r <= 1'b1;
         irq_s2_r <= 1'b1;
         port_s1_r <= 4'h0;
         port_s2_r <= 4'h0;
      end
      else
      begin
         irq_s1_r <= IRQ_N_PIN;
         irq_s2_r <= irq_s1_r;
         port_s1_r <= PORT_IRQ_PIN;
         port_s2_r <= port_s1_r;
      end
   end

   // External request: irq pin low, or any port line high when enabled
   assign ext_req = external_irq_enable_r & (~irq_s2_r |
      (ctrl_r[`LPMC_CTRL_PORT_IRQ] & (|port_s2_r)));
   // Timer request only with its enable set
   assign tmr_req = tmr_pend(timer_status_control_r[`LPMC_TSC_OVF_FLAG],
      timer_status_control_r[`LPMC_TSC_OVF_EN]) |
      tmr_pend(timer_status_control_r[`LPMC_TSC_RTI_FLAG],
      timer_status_control_r[`LPMC_TSC_RTI_EN]);

   assign enter_stop = (state_r == S_RUN) & STOP_EXEC &
      ~ctrl_r[`LPMC_CTRL_HALT_SEL];
   assign enter_halt = (state_r == S_RUN) & STOP_EXEC &
      ctrl_r[`LPMC_CTRL_HALT_SEL];
   assign enter_wait = (state_r == S_RUN) & WAIT_EXEC & ~STOP_EXEC;
   assign dly_start = ((state_r == S_STOP) & ext_req) |
      ((state_r == S_HALT) & (ext_req | tmr_req));
   assign dly_cnt = ctrl_r[`LPMC_CTRL_LONG_DLY] ? LONG_CNT :
      SHORT_CNT;
   // Oscillator, timers and watchdog held off from stop entry to the
   // end of the exit delay, and come back in the same cycle as the core clock
   assign osc_hold = enter_stop | (stop_osc_r & ~dly_done);

   // ---------------------------------------------------------------
   // Mode sequencer
   // ---------------------------------------------------------------
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         S_RUN:
         begin
            if (enter_stop)
               state_nxt = S_STOP;
            else if (enter_halt)
               state_nxt = S_HALT;
            else if (enter_wait)
               state_nxt = S_WAIT;
         end
         S_STOP:
            if (ext_req)
               state_nxt = S_DLY;
         S_HALT:
            if (ext_req | tmr_req)
               state_nxt = S_DLY;
         S_WAIT:
            // Wait resumes at once; no oscillator restart involved
            if (ext_req | tmr_req)
               state_nxt = S_RUN;
         S_DLY:
            if (dly_done)
               state_nxt = S_RUN;
         default:
            state_nxt = S_RUN;
      endcase
   end

   always @(posedge CLK)
   begin
      if (!RST_N)
         state_r <= S_RUN;
      else
         state_r <= state_nxt;
   end

   lpmc_delay #(
      .W(CW)
   ) u_delay (
      .clk(CLK),
      .rst_n(RST_N),
      .start(dly_start),
      .count(dly_cnt),
      .busy_r(dly_busy),
      .done_r(dly_done)
   );

   // ---------------------------------------------------------------
   // Clock enables and status outputs
   // ---------------------------------------------------------------
   always @(posedge CLK)
   begin
      if (!RST_N)
      begin
         stop_osc_r <= 1'b0;
         CPU_CLK_EN <= 1'b1;
         TIMER_CLK_EN <= 1'b1;
         OSC_EN <= 1'b1;
         WDOG_RUN <= 1'b0;
         WAKE_IRQ <= 1'b0;
         LP_ACTIVE <= 1'b0;
      end
      else
      begin
         // Oscillator stays off through the stop exit delay
         if (enter_stop)
            stop_osc_r <= 1'b1;
         else if (dly_done)
            stop_osc_r <= 1'b0;
         CPU_CLK_EN <= (state_nxt == S_RUN);
         OSC_EN <= ~osc_hold;
         TIMER_CLK_EN <= ~osc_hold;
         WDOG_RUN <= ctrl_r[`LPMC_CTRL_WDOG_EN] & ~osc_hold;
         // Every exit from low power is interrupt driven, so the
         // vector is due even if the source let go during the delay
         WAKE_IRQ <= (state_nxt == S_RUN) & (state_r != S_RUN);
         LP_ACTIVE <= (state_nxt != S_RUN);
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ---------------------------------------------------------------
   assign ahb_go = HSEL & HREADY & HTRANS[1];

   always @(posedge CLK)
   begin
      if (!RST_N)
      begin
         a_addr_r <= 8'h00;
         a_wr_r <= 1'b0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
      else
      begin
         a_wr_r <= ahb_go & HWRITE;
         if (ahb_go)
            a_addr_r <= HADDR[7:0];
      end
   end

   // Read data registered at address phase so it stands in data phase
   // Limitation: a read right behind a write to one register sees the
   // old value, as the write lands only at the end of its data phase
   always @(posedge CLK)
   begin
      if (!RST_N)
         HRDATA <= 32'h0000_0000;
      else if (ahb_go & ~HWRITE)
      begin
         case (HADDR[7:0])
            `LPMC_CTRL_OFS:
               HRDATA <= {28'h0000000, ctrl_r};
            `LPMC_STAT_OFS:
               HRDATA <= {26'h0000000, dly_busy, state_r};
            `LPMC_TSC_OFS:
               HRDATA <= {24'h000000, timer_status_control_r};
            `LPMC_IRQC_OFS:
               HRDATA <= {30'h00000000, imask_r, external_irq_enable_r};
            default:
               HRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Control, timer status/control and interrupt control registers
   // ---------------------------------------------------------------
   always @(posedge CLK)
   begin
      if (!RST_N)
         ctrl_r <= `LPMC_CTRL_RST;
      else if (wr_hit(a_wr_r, a_addr_r, `LPMC_CTRL_OFS))
         ctrl_r <= HWDATA[3:0];
   end

   always @(posedge CLK)
   begin
      if (!RST_N)
         timer_status_control_r <= `LPMC_TSC_RST;
      else
      begin
         if (wr_hit(a_wr_r, a_addr_r, `LPMC_TSC_OFS))
         begin
            // Writing one to a flag clears it; enables written directly
            timer_status_control_r[3:0] <= HWDATA[3:0];
            timer_status_control_r[`LPMC_TSC_OVF_EN] <=
               HWDATA[`LPMC_TSC_OVF_EN];
            timer_status_control_r[`LPMC_TSC_RTI_EN] <=
               HWDATA[`LPMC_TSC_RTI_EN];
            if (HWDATA[`LPMC_TSC_OVF_FLAG])
               timer_status_control_r[`LPMC_TSC_OVF_FLAG] <= 1'b0;
            if (HWDATA[`LPMC_TSC_RTI_FLAG])
               timer_status_control_r[`LPMC_TSC_RTI_FLAG] <= 1'b0;
         end
         // Timer events beat a software clear
         if (TIMER_OVF_EVT & TIMER_CLK_EN)
            timer_status_control_r[`LPMC_TSC_OVF_FLAG] <= 1'b1;
         if (TIMER_RTI_EVT & TIMER_CLK_EN)
            timer_status_control_r[`LPMC_TSC_RTI_FLAG] <= 1'b1;
         // Stop entry wipes pending timer requests, low nibble kept
         if (enter_stop)
         begin
            timer_status_control_r[`LPMC_TSC_OVF_FLAG] <= 1'b0;
            timer_status_control_r[`LPMC_TSC_RTI_FLAG] <= 1'b0;
            timer_status_control_r[`LPMC_TSC_OVF_EN] <= 1'b0;
            timer_status_control_r[`LPMC_TSC_RTI_EN] <= 1'b0;
         end
      end
   end

   always @(posedge CLK)
   begin
      if (!RST_N)
      begin
         external_irq_enable_r <= IRQC_RST[`LPMC_IRQC_EXT_EN];
         imask_r <= IRQC_RST[`LPMC_IRQC_IMASK];
      end
      else if (enter_stop | enter_halt | enter_wait)
      begin
         imask_r <= 1'b0;
         external_irq_enable_r <= 1'b1;
      end
      else if (wr_hit(a_wr_r, a_addr_r, `LPMC_IRQC_OFS))
      begin
         imask_r <= HWDATA[`LPMC_IRQC_IMASK];
         external_irq_enable_r <= HWDATA[`LPMC_IRQC_EXT_EN];
      end
   end
endmodule

// [verification/lpmc_monitor.sv]
// Port checker for the low-power mode controller.
// Assumes one clock, RST_N synchronous and active low.
`timescale 1ns/1ps
module lpmc_monitor (
   input wire CLK,
   input wire RST_N,
   input wire STOP_EXEC,
   input wire WAIT_EXEC,
   input wire CPU_CLK_EN,
   input wire TIMER_CLK_EN,
   input wire OSC_EN,
   input wire WDOG_RUN,
   input wire WAKE_IRQ,
   input wire LP_ACTIVE,
   input wire HREADYOUT,
   input wire HRESP
);
   // ----------------------------------------
   // Mode entry, wake, clock enable and bus response checks
   // ----------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence enter_req;
      CPU_CLK_EN && !LP_ACTIVE && (STOP_EXEC || WAIT_EXEC);
   endsequence
   sequence lp_held;
      !CPU_CLK_EN && LP_ACTIVE;
   endsequence
   chk_entry_gates_cpu: assert property (enter_req |=> lp_held)
      else $error("core clock not gated on entry");
   chk_wait_keeps_timer: assert property (CPU_CLK_EN && !LP_ACTIVE &&
      WAIT_EXEC && !STOP_EXEC |=> OSC_EN && TIMER_CLK_EN)
      else $error("wait entry stopped timer or oscillator");
   chk_osc_off_wdog: assert property (!OSC_EN |-> !WDOG_RUN &&
      !TIMER_CLK_EN) else $error("watchdog or timer runs without osc");
   chk_stop_quiet: assert property ($rose(OSC_EN) |->
      !$past(OSC_EN, 16)) else $error("oscillator back too early");
   chk_run_clocks: assert property (!LP_ACTIVE |-> CPU_CLK_EN &&
      OSC_EN && TIMER_CLK_EN) else $error("clock off while running");
   chk_gated_is_lp: assert property (!CPU_CLK_EN |-> LP_ACTIVE)
      else $error("core clock off outside low power");
   chk_wake_pulse: assert property (WAKE_IRQ |=> !WAKE_IRQ)
      else $error("wake pulse longer than one cycle");
   chk_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus not ready or error response");
   chk_wake_cpu_on: assert property (WAKE_IRQ |-> CPU_CLK_EN &&
      !LP_ACTIVE) else $error("wake pulse while core clock gated");
endmodule
bind lpmc_top lpmc_monitor u_mon (.CLK(CLK), .RST_N(RST_N),
   .STOP_EXEC(STOP_EXEC), .WAIT_EXEC(WAIT_EXEC), .CPU_CLK_EN(CPU_CLK_EN),
   .TIMER_CLK_EN(TIMER_CLK_EN), .OSC_EN(OSC_EN), .WDOG_RUN(WDOG_RUN),
   .WAKE_IRQ(WAKE_IRQ), .LP_ACTIVE(LP_ACTIVE), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP));

// [verification/lpmc_core_model.sv]
// Core model issuing stop and wait instructions, counting vectors.
// Assumes op requests are one-cycle pulses from the bench.
`timescale 1ns/1ps
module lpmc_core_model (
   input wire clk,
   input wire rst_n,
   input wire op_stop,
   input wire op_wait,
   input wire cpu_clk_en,
   input wire wake_irq,
   output reg stop_exec,
   output reg wait_exec,
   output reg [7:0] vec_count
);
   // ----------------------------------------
   // Instruction issue
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         stop_exec <= 1'b0;
         wait_exec <= 1'b0;
         vec_count <= 8'h00;
      end
      else
      begin
         // A gated core cannot execute anything
         stop_exec <= op_stop && cpu_clk_en;
         wait_exec <= op_wait && cpu_clk_en;
         if (wake_irq)
            vec_count <= vec_count + 8'h01;
      end
   end
endmodule

// [verification/low_power_mode_control_tb_top.sv]
// Testbench for the low-power mode controller.
// Assumes the AHB-Lite slave answers with no wait states.
`timescale 1ns/1ps
module low_power_mode_control_tb_top;
   logic CLK, RST_N, HSEL, HWRITE, op_stop, op_wait, IRQ_N_PIN;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [3:0] PORT_IRQ_PIN;
   logic TIMER_OVF_EVT, TIMER_RTI_EVT, STOP_EXEC, WAIT_EXEC, HREADYOUT;
   logic HRESP, CPU_CLK_EN, TIMER_CLK_EN, OSC_EN, WDOG_RUN, WAKE_IRQ;
   logic LP_ACTIVE;
   logic [7:0] vec_count;
   int n_mismatch, check_count, cyc, n;
   lpmc_top dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .STOP_EXEC(STOP_EXEC), .WAIT_EXEC(WAIT_EXEC),
      .IRQ_N_PIN(IRQ_N_PIN), .PORT_IRQ_PIN(PORT_IRQ_PIN),
      .TIMER_OVF_EVT(TIMER_OVF_EVT), .TIMER_RTI_EVT(TIMER_RTI_EVT),
      .CPU_CLK_EN(CPU_CLK_EN), .TIMER_CLK_EN(TIMER_CLK_EN), .OSC_EN(OSC_EN),
      .WDOG_RUN(WDOG_RUN), .WAKE_IRQ(WAKE_IRQ), .LP_ACTIVE(LP_ACTIVE));
   lpmc_core_model core (.clk(CLK), .rst_n(RST_N), .op_stop(op_stop),
      .op_wait(op_wait), .cpu_clk_en(CPU_CLK_EN), .wake_irq(WAKE_IRQ),
      .stop_exec(STOP_EXEC), .wait_exec(WAIT_EXEC), .vec_count(vec_count));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d,
      output logic [31:0] r);
      @(posedge CLK);
      HSEL <= 1'b1; HTRANS <= 2'h2; HADDR <= a; HWRITE <= w;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      r = HRDATA;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   task automatic enter(input logic s);
      @(posedge CLK);
      if (s) op_stop <= 1'b1; else op_wait <= 1'b1;
      @(posedge CLK);
      op_stop <= 1'b0; op_wait <= 1'b0;
      repeat (3) @(posedge CLK);
   endtask
   task automatic evt(input logic rti);
      @(posedge CLK);
      if (rti) TIMER_RTI_EVT <= 1'b1; else TIMER_OVF_EVT <= 1'b1;
      @(posedge CLK);
      TIMER_RTI_EVT <= 1'b0; TIMER_OVF_EVT <= 1'b0;
   endtask
   task automatic wake_wait(input int lo, input int hi);
      n = 0;
      while (CPU_CLK_EN !== 1'b1 && n < 5000)
      begin
         @(posedge CLK);
         n++;
      end
      chk(32'(n >= lo && n <= hi), 32'h1);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      rd(32'h0, 32'h0); rd(32'h8, 32'h0); rd(32'hc, 32'h3);
      rd(32'h4, 32'h1);
      wr(32'h10, 32'hff); rd(32'h10, 32'h0);
   endtask
   task automatic t_stop;
      wr(32'h0, 32'h8); wr(32'h8, 32'h3f); wr(32'hc, 32'h2); evt(1'b0);
      rd(32'h8, 32'hbf);
      chk(32'(WDOG_RUN), 32'h1);
      enter(1'b1);
      chk(32'({OSC_EN, WDOG_RUN, CPU_CLK_EN}), 32'h0);
      rd(32'h8, 32'h0f);
      rd(32'hc, 32'h1);
      rd(32'h4, 32'h2);
      chk(32'({LP_ACTIVE, TIMER_CLK_EN}), 32'h2);
      evt(1'b0);
      rd(32'h8, 32'h0f);
      PORT_IRQ_PIN <= 4'hf;
      repeat (40) @(posedge CLK);
      chk(32'(OSC_EN), 32'h0);
      PORT_IRQ_PIN <= 4'h0; IRQ_N_PIN <= 1'b0;
      wake_wait(17, 30);
      IRQ_N_PIN <= 1'b1;
   endtask
   task automatic t_halt;
      wr(32'h0, 32'h9); wr(32'h8, 32'h20); wr(32'hc, 32'h2);
      enter(1'b1);
      chk(32'({OSC_EN, WDOG_RUN, CPU_CLK_EN}), 32'h6);
      rd(32'hc, 32'h1);
      rd(32'h4, 32'h4);
      chk(32'(TIMER_CLK_EN), 32'h1);
      evt(1'b0);
      wake_wait(14, 30);
      wr(32'h8, 32'h80);
   endtask
   task automatic t_wait;
      wr(32'h0, 32'h1);
      wr(32'hc, 32'h2); wr(32'h8, 32'h10);
      enter(1'b0);
      rd(32'h4, 32'h8);
      chk(32'({TIMER_CLK_EN, CPU_CLK_EN}), 32'h2);
      rd(32'hc, 32'h1);
      evt(1'b1);
      wake_wait(0, 4);
   endtask
   task automatic t_long;
      wr(32'h0, 32'h6);
      enter(1'b1);
      PORT_IRQ_PIN <= 4'h1;
      wake_wait(4065, 4080);
      PORT_IRQ_PIN <= 4'h0;
      // Core model counted the last pulse at the edge wake_wait returned on; it shows after this edge
      @(posedge CLK);
      chk(32'(vec_count), 32'h4);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------
   initial
   begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   always @(posedge CLK)
   begin
      cyc++;
      // Runs take about 4300 cycles; the margin covers slow wakes
      if (cyc == 20000)
      begin
         n_mismatch++;
         report_and_stop;
      end
   end
   initial
   begin
      RST_N = 1'b0; HSEL = 1'b0; HWRITE = 1'b0; HADDR = 32'h0;
      HWDATA = 32'h0; HTRANS = 2'h0; HSIZE = 3'h2; op_stop = 1'b0;
      op_wait = 1'b0; IRQ_N_PIN = 1'b1; PORT_IRQ_PIN = 4'h0;
      TIMER_OVF_EVT = 1'b0; TIMER_RTI_EVT = 1'b0;
      n_mismatch = 0; check_count = 0;
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      t_regs;
      t_stop;
      t_halt;
      t_wait;
      t_long;
      report_and_stop;
   end
endmodule
